// ===== logic/fifo_status_pkg.sv
// Shared constants and types for the sensor word buffer read-out block
package fifo_status_pkg;

  // ----------------------------------------
  // Register addresses (7-bit serial bus address)
  // ----------------------------------------
  localparam logic [6:0] ADDR_WTM_LOW = 7'h07;
  localparam logic [6:0] ADDR_WTM_HIGH = 7'h08;
  localparam logic [6:0] ADDR_BATCH_CFG = 7'h0B;
  localparam logic [6:0] ADDR_BATCH_TH_LOW = 7'h0C;
  localparam logic [6:0] ADDR_IRQ1_ROUTE = 7'h0D;
  localparam logic [6:0] ADDR_IRQ2_ROUTE = 7'h0E;
  localparam logic [6:0] ADDR_CTRL = 7'h12;
  localparam logic [6:0] ADDR_LEVEL_LOW = 7'h1B;
  localparam logic [6:0] ADDR_FLAGS_LEVEL_HIGH = 7'h1C;
  localparam logic [6:0] ADDR_TAG = 7'h78;
  localparam logic [6:0] ADDR_X_LOW = 7'h79;
  localparam logic [6:0] ADDR_X_HIGH = 7'h7A;
  localparam logic [6:0] ADDR_Y_LOW = 7'h7B;
  localparam logic [6:0] ADDR_Y_HIGH = 7'h7C;
  localparam logic [6:0] ADDR_Z_LOW = 7'h7D;
  localparam logic [6:0] ADDR_Z_HIGH = 7'h7E;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int STS_WTM_BIT = 7;
  localparam int STS_OVR_BIT = 6;
  localparam int STS_FULL_BIT = 5;
  localparam int STS_CNT_BIT = 4;
  localparam int STS_STICKY_BIT = 3;
  localparam int ROUTE_WTM_BIT = 3;
  localparam int ROUTE_OVR_BIT = 4;
  localparam int ROUTE_FULL_BIT = 5;
  localparam int ROUTE_CNT_BIT = 6;
  localparam int CTRL_BDU_BIT = 6;
  localparam int BATCH_SEL_LSB = 5;
  localparam int SPI_READ_BIT = 7;

  // ----------------------------------------
  // Sizes and reset values
  // ----------------------------------------
  localparam int WORD_BYTES = 7;
  localparam int DEPTH = 256;
  localparam logic [8:0] DEPTH_CNT = 9'h100;
  localparam logic [8:0] FULL_WARN_CNT = 9'h0FF;
  localparam logic [8:0] WTM_RST = 9'h000;
  localparam logic [9:0] BATCH_TH_RST = 10'h000;
  localparam logic [1:0] BATCH_SEL_RST = 2'h0;
  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ----------------------------------------
  // Source codes carried in the tag byte
  // ----------------------------------------
  typedef enum logic [4:0] {
    SRC_EMPTY = 5'h00, SRC_GYRO = 5'h01, SRC_ACCEL = 5'h02, SRC_TEMP = 5'h03,
    SRC_TSTAMP = 5'h04, SRC_CFG_CHANGE = 5'h05, SRC_ACCEL_T2 = 5'h06,
    SRC_ACCEL_T1 = 5'h07, SRC_ACCEL_2X = 5'h08, SRC_ACCEL_3X = 5'h09,
    SRC_GYRO_T2 = 5'h0A, SRC_GYRO_T1 = 5'h0B, SRC_GYRO_2X = 5'h0C,
    SRC_GYRO_3X = 5'h0D, SRC_HUB0 = 5'h0E, SRC_HUB1 = 5'h0F, SRC_HUB2 = 5'h10,
    SRC_HUB3 = 5'h11, SRC_STEPS = 5'h12, SRC_FUSION_ROT = 5'h13,
    SRC_FUSION_BIAS = 5'h16, SRC_FUSION_GRAV = 5'h17, SRC_HUB_NACK = 5'h19,
    SRC_LEARN_RESULT = 5'h1A, SRC_LEARN_FILTER = 5'h1B, SRC_LEARN_FEATURE = 5'h1C,
    SRC_ACCEL_CH2 = 5'h1D, SRC_GYRO_STAB = 5'h1E
  } src_code_t;

  typedef enum logic [1:0] {
    SEL_ACCEL = 2'h0, SEL_GYRO = 2'h1, SEL_STAB_A = 2'h2, SEL_STAB_B = 2'h3
  } batch_sel_t;

endpackage

// ===== logic/reg_access_if.sv
// Register access strobes between the serial link and the register file
interface reg_access_if;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  modport link (output addr, output wdata, output wr, output rd, input rdata);
  modport regs (input addr, input wdata, input wr, input rd, output rdata);
endinterface

// ===== logic/serial_reg_link.sv
// Four-wire serial register port, clock sampled by the system clock
module serial_reg_link (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  reg_access_if.link bus
);
  import fifo_status_pkg::*;

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic sclk_d_ff;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_ff <= 3'h7;
      sync_ff <= 3'h7;
      sclk_d_ff <= 1'b1;
    end else begin
      meta_ff <= {sclk, cs_n, mosi};
      sync_ff <= meta_ff;
      sclk_d_ff <= sync_ff[2];
    end
  end

  logic sel;
  logic rise;
  logic fall;
  assign sel = !sync_ff[1];
  assign rise = sel && sync_ff[2] && !sclk_d_ff;
  assign fall = sel && !sync_ff[2] && sclk_d_ff;

  // ----------------------------------------
  // Frame: command byte, then data bytes with address auto-increment
  // ----------------------------------------
  logic [2:0] bit_ff;
  logic [7:0] rx_ff;
  logic [7:0] tx_ff;
  logic in_data_ff;
  logic is_read_ff;
  logic [6:0] addr_ff;
  logic wr_ff;
  logic rd_now;
  logic [7:0] nxt_rx;
  assign nxt_rx = {rx_ff[6:0], sync_ff[0]};
  // Fetch only when the host starts clocking a byte out, so no prefetch side effect
  assign rd_now = fall && in_data_ff && is_read_ff && (bit_ff == 3'h0);

  always_ff @(posedge clk) begin
    if (!nrst || !sel) begin
      bit_ff <= 3'h0;
      rx_ff <= 8'h00;
      in_data_ff <= 1'b0;
      is_read_ff <= 1'b0;
      addr_ff <= 7'h00;
      wr_ff <= 1'b0;
    end else begin
      wr_ff <= 1'b0;
      if (rise) begin
        rx_ff <= nxt_rx;
        bit_ff <= bit_ff + 3'h1;
        if (bit_ff == 3'h7) begin
          if (!in_data_ff) begin
            in_data_ff <= 1'b1;
            is_read_ff <= nxt_rx[SPI_READ_BIT];
            addr_ff <= nxt_rx[6:0];
          end else if (is_read_ff) begin
            addr_ff <= addr_ff + 7'h01;
          end else begin
            wr_ff <= 1'b1;
          end
        end
      end else if (wr_ff) begin
        addr_ff <= addr_ff + 7'h01;
      end
    end
  end

  // First bit leaves in the fetch cycle, the rest on later falling edges
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_ff <= 8'h00;
      miso <= 1'b0;
    end else if (rd_now) begin
      miso <= bus.rdata[7];
      tx_ff <= {bus.rdata[6:0], 1'b0};
    end else if (fall) begin
      miso <= tx_ff[7];
      tx_ff <= {tx_ff[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= sel;
    end
  end

  assign bus.addr = addr_ff;
  assign bus.wdata = rx_ff;
  assign bus.wr = wr_ff;
  assign bus.rd = rd_now;
endmodule

// ===== logic/word_store.sv
// Circular word storage in flip-flops with oldest-word overwrite
module word_store (
  input wire logic clk,
  input wire logic nrst,
  input wire logic push,
  input wire logic [8*fifo_status_pkg::WORD_BYTES-1:0] push_word,
  input wire logic advance,
  output logic [8*fifo_status_pkg::WORD_BYTES-1:0] head_word
);
  import fifo_status_pkg::*;

  logic [8*WORD_BYTES-1:0] mem [DEPTH];
  logic [7:0] wr_ptr_ff;
  logic [7:0] rd_ptr_ff;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= push_word;
    end
  end

  // Advance covers both a pop and the drop of the oldest word on overwrite
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_ptr_ff <= 8'h00;
      rd_ptr_ff <= 8'h00;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 8'h01;
      end
      if (advance) begin
        rd_ptr_ff <= rd_ptr_ff + 8'h01;
      end
    end
  end

  assign head_word = mem[rd_ptr_ff];
endmodule

// ===== logic/sensor_fifo_status_readout.sv
// Status, flag and read-out register block of the sensor word buffer
// ----------------------------------------
// Notes on behaviour
// RULE1 - Unread word count is 9 bits: low byte in level reg, bit 8 in status bit 0
// RULE2 - Watermark flag bit 7 high while count is at or above threshold
// RULE3 - Overrun flag bit 6 set on overwrite when full, cleared by a word read
// RULE4 - Sticky overrun bit 3 set on overwrite, cleared only by reading status
// RULE5 - Full flag bit 5 when next stored word fills buffer or overruns
// RULE6 - Batch-count flag bit 4 at 10-bit threshold, cleared by status read
// RULE7 - Each flag routes to either interrupt pin under its own enable bit; sticky overrun bit 3 has no route bit here
// RULE8 - Level and status follow every write and read; bits 2 and 1 zero
// RULE9 - With block update set, host reads level before status; pair stays coherent
// RULE10 - Tag byte: source code bits 7-3, slot counter bits 2-1, bit 0 zero
// RULE11 - Code 0x00 when empty; gyro 0x01, accel 0x02 uncompressed
// RULE12 - Temperature 0x03, timestamp 0x04, configuration change 0x05
// RULE13 - Compressed: accel 0x08, 0x09; gyro 0x0C, 0x0D
// RULE14 - Earlier slots: accel 0x07, 0x06; gyro 0x0B, 0x0A
// RULE15 - Hub 0x0E-0x11, steps 0x12, fusion 0x13/16/17, nack 0x19, core 0x1A-0x1C
// RULE16 - Second accel channel 0x1D, stabilisation gyro 0x1E
// RULE17 - Six data bytes at 79h-7Eh: X low/high, Y low/high, Z low/high
// RULE18 - Slot counter steps and wraps on fastest main sensor batch event
// RULE19 - Batch sample counter cleared whenever the buffer is empty
// RULE20 - Batch source select: 00 accel, 01 gyro, 10/11 stabilisation gyro
// RULE21 - Reading the last data byte pops the word and decrements the count
// ----------------------------------------
module sensor_fifo_status_readout (
  input wire logic clk,
  input wire logic nrst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic push_valid,
  input wire fifo_status_pkg::src_code_t push_source,
  input wire logic [47:0] push_data,
  input wire logic accel_batch,
  input wire logic gyro_batch,
  input wire logic stab_batch,
  input wire logic slot_advance,
  output logic irq1,
  output logic irq2
);
  import fifo_status_pkg::*;

  reg_access_if bus ();

  serial_reg_link link_u (
    .clk(clk),
    .nrst(nrst),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .mosi(spi_mosi),
    .miso(spi_miso),
    .miso_oe(spi_miso_oe),
    .bus(bus.link)
  );

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  logic [8:0] wtm_ff;
  logic [9:0] batch_th_ff;
  logic [1:0] batch_sel_ff;
  logic [7:0] route1_ff;
  logic [7:0] route2_ff;
  logic bdu_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wtm_ff <= WTM_RST;
      batch_th_ff <= BATCH_TH_RST;
      batch_sel_ff <= BATCH_SEL_RST;
      route1_ff <= ROUTE_RST;
      route2_ff <= ROUTE_RST;
      bdu_ff <= 1'b0;
    end else if (bus.wr) begin
      case (bus.addr)
        ADDR_WTM_LOW: wtm_ff[7:0] <= bus.wdata;
        ADDR_WTM_HIGH: wtm_ff[8] <= bus.wdata[0];
        ADDR_BATCH_CFG: begin
          batch_sel_ff <= bus.wdata[BATCH_SEL_LSB+:2];
          batch_th_ff[9:8] <= bus.wdata[1:0];
        end
        ADDR_BATCH_TH_LOW: batch_th_ff[7:0] <= bus.wdata;
        ADDR_IRQ1_ROUTE: route1_ff <= bus.wdata;
        ADDR_IRQ2_ROUTE: route2_ff <= bus.wdata;
        ADDR_CTRL: bdu_ff <= bus.wdata[CTRL_BDU_BIT];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Word storage and level
  // ----------------------------------------
  logic [8:0] count_ff;
  logic [8:0] nxt_count;
  logic [1:0] slot_ff;
  logic [55:0] head_word;
  logic rd_status;
  logic do_pop;
  logic overwrite;

  assign rd_status = bus.rd && (bus.addr == ADDR_FLAGS_LEVEL_HIGH);
  assign do_pop = bus.rd && (bus.addr == ADDR_Z_HIGH) && (count_ff != 9'h000); // RULE21
  // Pushing into a full buffer drops the oldest word instead of the new one
  assign overwrite = push_valid && !do_pop && (count_ff == DEPTH_CNT); // RULE3

  word_store store_u (
    .clk(clk),
    .nrst(nrst),
    .push(push_valid),
    .push_word({push_source, slot_ff, 1'b0, push_data}), // RULE10
    .advance(do_pop || overwrite),
    .head_word(head_word)
  );

  always_comb begin
    nxt_count = count_ff;
    case ({push_valid, do_pop})
      2'b10: nxt_count = overwrite ? count_ff : count_ff + 9'h001;
      2'b01: nxt_count = count_ff - 9'h001; // RULE21
      default: nxt_count = count_ff;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      count_ff <= 9'h000;
    end else begin
      count_ff <= nxt_count; // RULE1 RULE8
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      slot_ff <= 2'h0;
    end else if (slot_advance) begin
      slot_ff <= slot_ff + 2'h1; // RULE18
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  logic wtm_flag_ff;
  logic full_flag_ff;
  logic ovr_flag_ff;
  logic sticky_ovr_ff;
  logic cnt_flag_ff;
  logic [9:0] batch_cnt_ff;
  logic batch_inc;

  // Level flags track the count of the same edge, so they never lag a transfer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wtm_flag_ff <= 1'b0;
      full_flag_ff <= 1'b0;
    end else begin
      wtm_flag_ff <= (nxt_count >= wtm_ff); // RULE2 RULE8
      full_flag_ff <= (nxt_count >= FULL_WARN_CNT); // RULE5
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ovr_flag_ff <= 1'b0;
    end else if (overwrite) begin
      ovr_flag_ff <= 1'b1; // RULE3
    end else if (do_pop) begin
      ovr_flag_ff <= 1'b0; // RULE3
    end
  end

  // Set wins over the read clear so an overrun during readout is not lost
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sticky_ovr_ff <= 1'b0;
    end else if (overwrite) begin
      sticky_ovr_ff <= 1'b1; // RULE4
    end else if (rd_status) begin
      sticky_ovr_ff <= 1'b0; // RULE4
    end
  end

  always_comb begin
    case (batch_sel_ff)
      SEL_ACCEL: batch_inc = accel_batch; // RULE20
      SEL_GYRO: batch_inc = gyro_batch; // RULE20
      default: batch_inc = stab_batch; // RULE20
    endcase
  end

  // Counter saturates rather than wrapping, so a missed read cannot re-fire it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      batch_cnt_ff <= 10'h000;
    end else if (nxt_count == 9'h000) begin
      batch_cnt_ff <= 10'h000; // RULE19
    end else if (batch_inc && batch_cnt_ff != 10'h3FF) begin
      batch_cnt_ff <= batch_cnt_ff + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_flag_ff <= 1'b0;
    end else if (batch_inc && nxt_count != 9'h000 && batch_th_ff != 10'h000
                 && (batch_cnt_ff + 10'h001) == batch_th_ff) begin
      cnt_flag_ff <= 1'b1; // RULE6
    end else if (rd_status) begin
      cnt_flag_ff <= 1'b0; // RULE6
    end
  end

  logic [7:0] status_live;
  always_comb begin
    status_live = ZERO_BYTE; // RULE8
    status_live[STS_WTM_BIT] = wtm_flag_ff;
    status_live[STS_OVR_BIT] = ovr_flag_ff;
    status_live[STS_FULL_BIT] = full_flag_ff;
    status_live[STS_CNT_BIT] = cnt_flag_ff;
    status_live[STS_STICKY_BIT] = sticky_ovr_ff;
    status_live[0] = count_ff[8]; // RULE1
  end

  // ----------------------------------------
  // Coherent level/status pair
  // ----------------------------------------
  logic [7:0] status_snap_ff;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      status_snap_ff <= ZERO_BYTE;
    end else if (bus.rd && bus.addr == ADDR_LEVEL_LOW) begin
      status_snap_ff <= status_live; // RULE9
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic empty;
  assign empty = (count_ff == 9'h000);

  always_comb begin
    case (bus.addr)
      ADDR_WTM_LOW: bus.rdata = wtm_ff[7:0];
      ADDR_WTM_HIGH: bus.rdata = {7'h00, wtm_ff[8]};
      ADDR_BATCH_CFG: bus.rdata = {1'b0, batch_sel_ff, 3'h0, batch_th_ff[9:8]};
      ADDR_BATCH_TH_LOW: bus.rdata = batch_th_ff[7:0];
      ADDR_IRQ1_ROUTE: bus.rdata = route1_ff;
      ADDR_IRQ2_ROUTE: bus.rdata = route2_ff;
      ADDR_CTRL: bus.rdata = {1'b0, bdu_ff, 6'h00};
      ADDR_LEVEL_LOW: bus.rdata = count_ff[7:0]; // RULE1
      ADDR_FLAGS_LEVEL_HIGH: bus.rdata = bdu_ff ? status_snap_ff : status_live; // RULE9
      // Empty reads code 0x00 whatever stale word sits at the head
      ADDR_TAG: begin
        bus.rdata = head_word[55:48]; // RULE10 RULE12 RULE13 RULE14 RULE15 RULE16
        if (empty) begin
          bus.rdata = {SRC_EMPTY, slot_ff, 1'b0}; // RULE11
        end
      end
      ADDR_X_LOW: bus.rdata = head_word[7:0]; // RULE17
      ADDR_X_HIGH: bus.rdata = head_word[15:8]; // RULE17
      ADDR_Y_LOW: bus.rdata = head_word[23:16]; // RULE17
      ADDR_Y_HIGH: bus.rdata = head_word[31:24]; // RULE17
      ADDR_Z_LOW: bus.rdata = head_word[39:32]; // RULE17
      ADDR_Z_HIGH: bus.rdata = head_word[47:40]; // RULE17
      default: bus.rdata = ZERO_BYTE;
    endcase
  end

  // ----------------------------------------
  // Interrupt routing
  // ----------------------------------------
  logic [7:0] flag_vec;
  always_comb begin
    flag_vec = ZERO_BYTE;
    flag_vec[ROUTE_WTM_BIT] = wtm_flag_ff;
    flag_vec[ROUTE_OVR_BIT] = ovr_flag_ff;
    flag_vec[ROUTE_FULL_BIT] = full_flag_ff;
    flag_vec[ROUTE_CNT_BIT] = cnt_flag_ff;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq1 <= 1'b0;
      irq2 <= 1'b0;
    end else begin
      irq1 <= |(flag_vec & route1_ff); // RULE7
      irq2 <= |(flag_vec & route2_ff); // RULE7
    end
  end
endmodule

// ===== testbench/fifo_readout_props.sv
// Port-level assertions for the sensor word buffer read-out block
module fifo_readout_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic push_valid,
  input wire logic accel_batch,
  input wire logic gyro_batch,
  input wire logic stab_batch,
  input wire logic slot_advance,
  input wire logic irq1,
  input wire logic irq2
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Quiet-time counters
  // ----------------------------------------
  logic [3:0] idle_ff;
  logic [3:0] cs_idle_ff;
  logic act;
  assign act = !spi_cs_n || push_valid || accel_batch || gyro_batch || stab_batch || slot_advance;
  always_ff @(posedge clk) begin
    if (!nrst || act) idle_ff <= 4'h0;
    else if (idle_ff != 4'hf) idle_ff <= idle_ff + 4'h1;
  end
  // Only the serial link can clear a flag, so pushes do not reset this one
  always_ff @(posedge clk) begin
    if (!nrst || !spi_cs_n) cs_idle_ff <= 4'h0;
    else if (cs_idle_ff != 4'hf) cs_idle_ff <= cs_idle_ff + 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_reset_quiet: assert property ($rose(nrst) |-> !irq1 && !irq2 && !spi_miso_oe && !spi_miso)
    else $error("outputs not quiet after reset");
  a_oe_frame: assert property (!spi_cs_n [*5] |-> spi_miso_oe)
    else $error("miso not driven inside frame");
  a_oe_idle: assert property (spi_cs_n [*5] |-> !spi_miso_oe)
    else $error("miso driven outside frame");
  a_miso_hold: assert property ((spi_sclk && !spi_cs_n) [*2] |=> $stable(spi_miso))
    else $error("miso moved while serial clock high");
  a_miso_idle: assert property (spi_cs_n [*8] |-> $stable(spi_miso))
    else $error("miso moved between frames");
  a_irq1_quiet: assert property (idle_ff >= 4'h8 |-> $stable(irq1))
    else $error("irq1 changed without cause");
  a_irq2_quiet: assert property (idle_ff >= 4'h8 |-> $stable(irq2))
    else $error("irq2 changed without cause");
  a_irq1_no_fall: assert property (cs_idle_ff >= 4'h8 |-> !$fell(irq1))
    else $error("irq1 fell without a host access");
  a_irq2_no_fall: assert property (cs_idle_ff >= 4'h8 |-> !$fell(irq2))
    else $error("irq2 fell without a host access");
  c_irq1: cover property ($rose(irq1));
  c_irq2: cover property ($rose(irq2));
  c_read_one: cover property (!spi_cs_n [*5] ##1 spi_miso);
endmodule

bind sensor_fifo_status_readout fifo_readout_props u_props (
  .clk(clk), .nrst(nrst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
  .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .push_valid(push_valid),
  .accel_batch(accel_batch), .gyro_batch(gyro_batch), .stab_batch(stab_batch),
  .slot_advance(slot_advance), .irq1(irq1), .irq2(irq2)
);

// ===== testbench/serial_host.sv
// Behavioural host processor on the four-wire serial register port
module serial_host (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rbuf [7];
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Mode 3: drive on falling edge, sample late in the high phase
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      #40;
      sclk = 1'b1;
      #35;
      rx[i] = miso;
      #5;
    end
  endtask
  // Caller sets the order of single reads, level before status under block update
  task automatic xfer(input logic is_rd, input logic [6:0] addr, input int n,
                      input logic [7:0] wd);
    logic [7:0] rx;
    #3;
    cs_n = 1'b0;
    #50;
    shift({is_rd, addr}, rx);
    for (int k = 0; k < n; k++) begin
      shift(wd, rx);
      rbuf[k] = rx;
    end
    cs_n = 1'b1;
    // Released line must not keep looking valid
    mosi = ~mosi;
    // Whole-period frame length keeps sampling off the system clock edge
    #197;
  endtask
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the sensor word buffer read-out block
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import fifo_status_pkg::*;
  logic clk, nrst, sclk, cs_n, mosi, miso, miso_oe, push_valid;
  logic accel_batch, gyro_batch, stab_batch, slot_advance, irq1, irq2;
  src_code_t push_source;
  logic [47:0] push_data;
  logic [47:0] d;
  logic [3:0] sel;
  int n_errors = 0;
  int cmp_count = 0;
  int slot = 0;
  // Rows: every source code the buffer can carry
  logic [4:0] codes [27] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
    5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13,
    5'h16, 5'h17, 5'h19, 5'h1a, 5'h1b, 5'h1c, 5'h1d, 5'h1e};

  sensor_fifo_status_readout dut (
    .clk(clk), .nrst(nrst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe(miso_oe), .push_valid(push_valid),
    .push_source(push_source), .push_data(push_data), .accel_batch(accel_batch),
    .gyro_batch(gyro_batch), .stab_batch(stab_batch), .slot_advance(slot_advance),
    .irq1(irq1), .irq2(irq2)
  );
  serial_host host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic rd(input logic [6:0] a, input string what, input logic [7:0] exp);
    host.xfer(1'b1, a, 1, 8'h00);
    check(what, host.rbuf[0], exp);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    host.xfer(1'b0, a, 1, v);
  endtask
  task automatic push(input logic [4:0] src, input logic [47:0] v);
    @(posedge clk);
    push_valid <= 1'b1;
    push_source <= src_code_t'(src);
    push_data <= v;
    @(posedge clk);
    push_valid <= 1'b0;
  endtask
  // Bits: slot advance, stabilisation, gyro, accel
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    {slot_advance, stab_batch, gyro_batch, accel_batch} <= m;
    @(posedge clk);
    {slot_advance, stab_batch, gyro_batch, accel_batch} <= 4'h0;
  endtask
  task automatic irqs(input logic [1:0] e);
    @(posedge clk);
    @(negedge clk);
    check("irq pins", {6'h00, irq2, irq1}, {6'h00, e});
  endtask
  task automatic rst_chk(input int len);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (len) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    wr(ADDR_LEVEL_LOW, 8'h55);
    rd(ADDR_LEVEL_LOW, "level after reset", 8'h00);
    rd(ADDR_FLAGS_LEVEL_HIGH, "status after reset", 8'h80);
    rd(ADDR_WTM_LOW, "threshold after reset", 8'h00);
    rd(7'h30, "unmapped", 8'h00);
    irqs(2'b00);
  endtask

  initial begin
    #600us;
    n_errors++;
    results();
  end

  initial begin
    nrst = 1'b0;
    push_valid = 1'b0;
    push_source = SRC_EMPTY;
    push_data = 48'h0;
    {slot_advance, stab_batch, gyro_batch, accel_batch} = 4'h0;
    rst_chk(12);
    // ----------------------------------------
    // Table: tag, slot and data for every source
    // ----------------------------------------
    for (int i = 0; i < 27; i++) begin
      pulse(4'h8);
      slot = (slot + 1) % 4;
      d = {6{8'(i)}} ^ 48'h5a3c_0f96_e1d2;
      push(codes[i], d);
      host.xfer(1'b1, ADDR_TAG, 7, 8'h00);
      check("tag", host.rbuf[0], {codes[i], 2'(slot), 1'b0});
      for (int k = 0; k < 6; k++) check("data byte", host.rbuf[k + 1], d[8 * k +: 8]);
      rd(ADDR_TAG, "empty tag", {5'h00, 2'(slot), 1'b0});
    end
    // ----------------------------------------
    // Batch counter per source select
    // ----------------------------------------
    wr(ADDR_WTM_LOW, 8'h03);
    wr(ADDR_BATCH_TH_LOW, 8'h02);
    wr(ADDR_IRQ2_ROUTE, 8'h40);
    for (int s = 0; s < 4; s++) begin
      sel = (s == 0) ? 4'h1 : (s == 1) ? 4'h2 : 4'h4;
      wr(ADDR_BATCH_CFG, {1'b0, 2'(s), 5'h00});
      push(5'h02, 48'h0);
      pulse(4'h7 & ~sel);
      pulse(4'h7 & ~sel);
      pulse(sel);
      rd(ADDR_FLAGS_LEVEL_HIGH, "batch below", 8'h00);
      pulse(sel);
      irqs(2'b10);
      rd(ADDR_FLAGS_LEVEL_HIGH, "batch hit", 8'h10);
      rd(ADDR_FLAGS_LEVEL_HIGH, "batch cleared", 8'h00);
      irqs(2'b00);
      host.xfer(1'b1, ADDR_TAG, 7, 8'h00);
    end
    // ----------------------------------------
    // Watermark, routing and block update
    // ----------------------------------------
    wr(ADDR_IRQ1_ROUTE, 8'h08);
    rd(ADDR_WTM_LOW, "threshold reg", 8'h03);
    push(5'h01, 48'h0);
    push(5'h01, 48'h0);
    rd(ADDR_LEVEL_LOW, "level two", 8'h02);
    rd(ADDR_FLAGS_LEVEL_HIGH, "below watermark", 8'h00);
    irqs(2'b00);
    push(5'h01, 48'h0);
    rd(ADDR_FLAGS_LEVEL_HIGH, "at watermark", 8'h80);
    irqs(2'b01);
    wr(ADDR_CTRL, 8'h40);
    wr(ADDR_WTM_LOW, 8'h04);
    rd(ADDR_LEVEL_LOW, "level snapshot", 8'h03);
    push(5'h01, 48'h0);
    rd(ADDR_FLAGS_LEVEL_HIGH, "status snapshot", 8'h00);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_LEVEL_LOW, "level four", 8'h04);
    rd(ADDR_FLAGS_LEVEL_HIGH, "live status", 8'h80);
    // ----------------------------------------
    // Full, overrun and pop
    // ----------------------------------------
    repeat (251) push(5'h01, 48'h0);
    rd(ADDR_LEVEL_LOW, "level 255", 8'hff);
    rd(ADDR_FLAGS_LEVEL_HIGH, "full warning", 8'ha0);
    push(5'h01, 48'h0);
    rd(ADDR_LEVEL_LOW, "level 256", 8'h00);
    rd(ADDR_FLAGS_LEVEL_HIGH, "full", 8'ha1);
    push(5'h01, 48'h0);
    rd(ADDR_LEVEL_LOW, "level at overrun", 8'h00);
    rd(ADDR_FLAGS_LEVEL_HIGH, "overrun", 8'he9);
    rd(ADDR_FLAGS_LEVEL_HIGH, "sticky cleared", 8'he1);
    host.xfer(1'b1, ADDR_TAG, 7, 8'h00);
    rd(ADDR_LEVEL_LOW, "level after pop", 8'hff);
    rd(ADDR_FLAGS_LEVEL_HIGH, "overrun cleared", 8'ha0);
    irqs(2'b01);
    rst_chk(2);
    results();
  end
endmodule
